// *** hdl/alt_mode_ctrl.sv ***
`timescale 1ns/100ps
module alt_mode_ctrl (
  input wire logic [7:0] port_mode_i, // Current port_mode_select value
  input wire logic global_low_power_n_i, // Global suspend control, 1 = running
  input wire logic stp_i, // ULPI stop from the link
  input wire logic bus_idle_i, // Register access engine idle
  output logic alt_active_o, // Any alternative interface selected
  output logic serial_active_o, // 3-pin or 6-pin serial selected
  output logic mode_exit_o, // Link leaves the alternative mode this cycle
  output logic clk_power_on_o // Internal clock circuitry powered
);

  logic three_wire;
  logic six_wire;
  logic carkit;

  assign three_wire = port_mode_i[ulpi_regs_pkg::PM_THREE_WIRE_SERIAL_SEL];
  assign six_wire = port_mode_i[ulpi_regs_pkg::PM_SIX_WIRE_SERIAL_SEL];
  assign carkit = port_mode_i[ulpi_regs_pkg::PM_CARKIT_UART_SEL];

  assign serial_active_o = three_wire | six_wire;
  assign alt_active_o = serial_active_o | carkit;

  // Stop from the link ends any alternative mode
  assign mode_exit_o = alt_active_o & bus_idle_i & stp_i;

  // Keep bit counts only in serial modes with the device awake
  always_comb
  begin
    if (serial_active_o && global_low_power_n_i)
    begin
      clk_power_on_o = port_mode_i[ulpi_regs_pkg::PM_SERIAL_MODE_CLK_KEEP_N];
    end
    else
    begin
      clk_power_on_o = global_low_power_n_i;
    end
  end

endmodule : alt_mode_ctrl

// *** hdl/pin_sync2.sv ***
`timescale 1ns/100ps
module pin_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk_i, // ULPI clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [WIDTH-1:0] async_i, // Signals from outside the clock domain
  output logic [WIDTH-1:0] sync_o // Synchronised copies
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule : pin_sync2

// *** hdl/ulpi_phy_interface_otg_ctrl_regs.sv ***
// How it works
// - Indicator invert bit at 1 inverts the fault input, at 0 passes it through.
// - Clock keep bit only steers power to internal clock circuitry.
// - Keep bit 0 leaves clock unpowered in 3/6-pin serial modes; 1 keeps it.
// - Keep bit counts only in 3/6-pin serial with global suspend control at 1.
// - Carkit bit at 1 turns the data interface into the UART interface.
// - Device clears the carkit bit itself when carkit mode ends.
// - Three-wire bit at 1 sends full/low-speed packets over 3-pin serial.
// - Device clears the three-wire bit itself when that mode ends.
// - Six-wire bit at 1 sends full/low-speed packets over 6-pin serial.
// - Device clears the six-wire bit itself when that mode ends.
// - Port mode register reads at 07h-09h; write 07h, set 08h, clear 09h.
// - Line control register reads at 0Ah-0Ch; write 0Ah, set 0Bh, clear 0Ch.
// - Power switch drive bit at 1 pulls the switch pin low, else high.
// - Pull-low bits 2 and 1 connect the data line pull-downs when set.
// - External valid select at 1 takes VBUS valid from the fault pin.
`timescale 1ns/100ps
module ulpi_phy_interface_otg_ctrl_regs (
  input wire logic sys_clk_i, // ULPI clock, 250 MHz
  input wire logic rst_n_i, // Async PHY reset, active low
  input wire logic stp_i, // ULPI stop from link
  input wire logic [7:0] data_i, // ULPI data driven by link
  output logic [7:0] data_o, // ULPI data driven by PHY
  output logic data_oe_o, // High while PHY drives ULPI data
  output logic dir_o, // ULPI direction, 1 = PHY owns bus
  output logic nxt_o, // ULPI next
  input wire logic fault_i, // External fault pin, asynchronous
  input wire logic vbus_cmp_i, // Internal OTG comparator, asynchronous
  input wire logic global_low_power_n_i, // Global suspend control, 1 = running
  output logic indicator_o, // Fault input after optional inversion
  output logic vbus_valid_o, // Selected VBUS valid indication
  output logic power_switch_out_n_o, // External power switch pin, active low
  output logic minus_line_pull_low_o, // Pull-down on minus data line
  output logic plus_line_pull_low_o, // Pull-down on plus data line
  output logic vbus_charge_o, // Charge VBUS through resistor
  output logic vbus_discharge_o, // Discharge VBUS through resistor
  output logic cable_id_sense_on_o, // ID pull-up and sampler
  output logic carkit_uart_o, // Data interface in carkit UART mode
  output logic three_wire_serial_o, // 3-pin serial interface active
  output logic six_wire_serial_o, // 6-pin serial interface active
  output logic clk_power_on_o // Internal clock circuitry powered
);

  ulpi_regs_pkg::access_state_t state_r;
  ulpi_regs_pkg::access_state_t state_nxt;

  logic [7:0] port_mode_r;
  logic [7:0] vbus_line_r;
  logic [5:0] addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] rd_data_r;
  logic nxt_r;
  logic dir_r;
  logic oe_r;

  logic [1:0] pins_sync;
  logic fault_s;
  logic vbus_cmp_s;
  logic alt_active;
  logic mode_exit;
  logic commit;
  logic bus_idle;
  logic [1:0] cmd_type;
  logic [5:0] cmd_addr;

  // Register addressing helpers

  function automatic logic hits_port_mode(input logic [5:0] addr);
    hits_port_mode = (addr == ulpi_regs_pkg::ADDR_PORT_MODE_WR) ||
                     (addr == ulpi_regs_pkg::ADDR_PORT_MODE_SET) ||
                     (addr == ulpi_regs_pkg::ADDR_PORT_MODE_CLR);
  endfunction : hits_port_mode

  function automatic logic hits_vbus_line(input logic [5:0] addr);
    hits_vbus_line = (addr == ulpi_regs_pkg::ADDR_VBUS_LINE_WR) ||
                     (addr == ulpi_regs_pkg::ADDR_VBUS_LINE_SET) ||
                     (addr == ulpi_regs_pkg::ADDR_VBUS_LINE_CLR);
  endfunction : hits_vbus_line

  function automatic ulpi_regs_pkg::reg_op_t addr_op(input logic [5:0] addr);
    if (addr == ulpi_regs_pkg::ADDR_PORT_MODE_SET || addr == ulpi_regs_pkg::ADDR_VBUS_LINE_SET)
    begin
      addr_op = ulpi_regs_pkg::OP_SET;
    end
    else if (addr == ulpi_regs_pkg::ADDR_PORT_MODE_CLR ||
             addr == ulpi_regs_pkg::ADDR_VBUS_LINE_CLR)
    begin
      addr_op = ulpi_regs_pkg::OP_CLEAR;
    end
    else
    begin
      addr_op = ulpi_regs_pkg::OP_WRITE;
    end
  endfunction : addr_op

  function automatic logic [7:0] apply_op(input logic [7:0] old_val,
                                          input logic [7:0] val,
                                          input ulpi_regs_pkg::reg_op_t op);
    case (op)
      ulpi_regs_pkg::OP_SET: apply_op = old_val | val;
      ulpi_regs_pkg::OP_CLEAR: apply_op = old_val & ~val;
      default: apply_op = val;
    endcase
  endfunction : apply_op

  // Pins from outside the ULPI clock domain

  pin_sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({fault_i, vbus_cmp_i}),
    .sync_o(pins_sync)
  );

  assign fault_s = pins_sync[1];
  assign vbus_cmp_s = pins_sync[0];

  alt_mode_ctrl u_alt_mode (
    .port_mode_i(port_mode_r),
    .global_low_power_n_i(global_low_power_n_i),
    .stp_i(stp_i),
    .bus_idle_i(bus_idle),
    .alt_active_o(alt_active),
    .serial_active_o(),
    .mode_exit_o(mode_exit),
    .clk_power_on_o(clk_power_on_o)
  );

  // Register access engine

  assign bus_idle = (state_r == ulpi_regs_pkg::ST_IDLE);
  assign cmd_type = data_i[ulpi_regs_pkg::CMD_TYPE_MSB:ulpi_regs_pkg::CMD_TYPE_LSB];
  assign cmd_addr = data_i[ulpi_regs_pkg::CMD_ADDR_MSB:0];
  assign commit = (state_r == ulpi_regs_pkg::ST_WR_STOP) && stp_i;

  // Pins are repurposed in alternative modes, so commands are not decoded then
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ulpi_regs_pkg::ST_IDLE:
      begin
        if (!alt_active && !stp_i && cmd_type == ulpi_regs_pkg::CMD_TYPE_REG_WR)
        begin
          state_nxt = ulpi_regs_pkg::ST_WR_DATA;
        end
        else if (!alt_active && !stp_i && cmd_type == ulpi_regs_pkg::CMD_TYPE_REG_RD)
        begin
          state_nxt = ulpi_regs_pkg::ST_RD_TURN;
        end
      end
      ulpi_regs_pkg::ST_WR_DATA:
      begin
        // Early stop aborts the write
        state_nxt = stp_i ? ulpi_regs_pkg::ST_IDLE : ulpi_regs_pkg::ST_WR_STOP;
      end
      ulpi_regs_pkg::ST_WR_STOP:
      begin
        if (stp_i)
        begin
          state_nxt = ulpi_regs_pkg::ST_IDLE;
        end
      end
      ulpi_regs_pkg::ST_RD_TURN: state_nxt = ulpi_regs_pkg::ST_RD_DATA;
      ulpi_regs_pkg::ST_RD_DATA: state_nxt = ulpi_regs_pkg::ST_RD_BACK;
      ulpi_regs_pkg::ST_RD_BACK: state_nxt = ulpi_regs_pkg::ST_IDLE;
      default: state_nxt = ulpi_regs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ulpi_regs_pkg::ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Command address and write byte capture
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      addr_r <= 6'h00;
      wr_data_r <= 8'h00;
    end
    else
    begin
      if (bus_idle)
      begin
        addr_r <= cmd_addr;
      end
      if (state_r == ulpi_regs_pkg::ST_WR_DATA)
      begin
        wr_data_r <= data_i;
      end
    end
  end

  // Next acknowledges the command byte and the write data byte
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      nxt_r <= 1'b0;
    end
    else
    begin
      nxt_r <= (state_nxt == ulpi_regs_pkg::ST_WR_DATA) ||
               (state_nxt == ulpi_regs_pkg::ST_WR_STOP) ||
               (state_nxt == ulpi_regs_pkg::ST_RD_TURN);
    end
  end

  // Turnaround cycle only after the read data; data_oe_o rises in the same cycle as dir_o
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dir_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else
    begin
      dir_r <= (state_nxt == ulpi_regs_pkg::ST_RD_DATA) ||
               (state_nxt == ulpi_regs_pkg::ST_RD_BACK);
      oe_r <= (state_nxt == ulpi_regs_pkg::ST_RD_DATA);
    end
  end

  // Read data: unmapped addresses return zero
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_r <= 8'h00;
    end
    else if (state_r == ulpi_regs_pkg::ST_RD_TURN)
    begin
      if (hits_port_mode(addr_r))
      begin
        rd_data_r <= port_mode_r;
      end
      else if (hits_vbus_line(addr_r))
      begin
        rd_data_r <= vbus_line_r;
      end
      else
      begin
        rd_data_r <= 8'h00;
      end
    end
  end

  // Registers

  // Mode bits clear themselves on exit; no write can coincide since
  // commands are not decoded while a mode is active
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      port_mode_r <= ulpi_regs_pkg::PM_RESET;
    end
    else if (mode_exit)
    begin
      port_mode_r[ulpi_regs_pkg::PM_CARKIT_UART_SEL] <= 1'b0;
      port_mode_r[ulpi_regs_pkg::PM_THREE_WIRE_SERIAL_SEL] <= 1'b0;
      port_mode_r[ulpi_regs_pkg::PM_SIX_WIRE_SERIAL_SEL] <= 1'b0;
    end
    else if (commit && hits_port_mode(addr_r))
    begin
      port_mode_r <= apply_op(port_mode_r, wr_data_r, addr_op(addr_r));
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      vbus_line_r <= ulpi_regs_pkg::VL_RESET;
    end
    else if (commit && hits_vbus_line(addr_r))
    begin
      vbus_line_r <= apply_op(vbus_line_r, wr_data_r, addr_op(addr_r));
    end
  end

  // Outputs

  assign data_o = rd_data_r;
  assign data_oe_o = oe_r;
  assign dir_o = dir_r;
  assign nxt_o = nxt_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      indicator_o <= 1'b0;
      vbus_valid_o <= 1'b0;
    end
    else
    begin
      indicator_o <= fault_s ^ port_mode_r[ulpi_regs_pkg::PM_INDICATOR_INVERT];
      if (vbus_line_r[ulpi_regs_pkg::VL_EXTERNAL_VBUS_VALID_SEL])
      begin
        vbus_valid_o <= fault_s ^ port_mode_r[ulpi_regs_pkg::PM_INDICATOR_INVERT];
      end
      else
      begin
        vbus_valid_o <= vbus_cmp_s;
      end
    end
  end

  // Controls straight from register bits
  assign power_switch_out_n_o = ~vbus_line_r[ulpi_regs_pkg::VL_POWER_SWITCH_DRIVE];
  assign minus_line_pull_low_o = vbus_line_r[ulpi_regs_pkg::VL_MINUS_LINE_PULL_LOW];
  assign plus_line_pull_low_o = vbus_line_r[ulpi_regs_pkg::VL_PLUS_LINE_PULL_LOW];
  assign vbus_charge_o = vbus_line_r[ulpi_regs_pkg::VL_VBUS_CHARGE];
  assign vbus_discharge_o = vbus_line_r[ulpi_regs_pkg::VL_VBUS_DISCHARGE];
  assign cable_id_sense_on_o = vbus_line_r[ulpi_regs_pkg::VL_CABLE_ID_SENSE_ON];

  // More than one mode bit is undefined; each pin group just follows its bit
  assign carkit_uart_o = port_mode_r[ulpi_regs_pkg::PM_CARKIT_UART_SEL];
  assign three_wire_serial_o = port_mode_r[ulpi_regs_pkg::PM_THREE_WIRE_SERIAL_SEL];
  assign six_wire_serial_o = port_mode_r[ulpi_regs_pkg::PM_SIX_WIRE_SERIAL_SEL];

endmodule : ulpi_phy_interface_otg_ctrl_regs

// *** hdl/ulpi_regs_pkg.sv ***
package ulpi_regs_pkg;

  // ULPI transmit command byte: type in [7:6], register address in [5:0]
  localparam logic [1:0] CMD_TYPE_REG_WR = 2'h2;
  localparam logic [1:0] CMD_TYPE_REG_RD = 2'h3;
  localparam int CMD_TYPE_MSB = 7;
  localparam int CMD_TYPE_LSB = 6;
  localparam int CMD_ADDR_MSB = 5;

  // Register addresses: read at all three, write, set, clear
  localparam logic [5:0] ADDR_PORT_MODE_WR = 6'h07;
  localparam logic [5:0] ADDR_PORT_MODE_SET = 6'h08;
  localparam logic [5:0] ADDR_PORT_MODE_CLR = 6'h09;
  localparam logic [5:0] ADDR_VBUS_LINE_WR = 6'h0a;
  localparam logic [5:0] ADDR_VBUS_LINE_SET = 6'h0b;
  localparam logic [5:0] ADDR_VBUS_LINE_CLR = 6'h0c;

  // port_mode_select fields
  localparam int PM_SIX_WIRE_SERIAL_SEL = 0;
  localparam int PM_THREE_WIRE_SERIAL_SEL = 1;
  localparam int PM_CARKIT_UART_SEL = 2;
  localparam int PM_SERIAL_MODE_CLK_KEEP_N = 3;
  localparam int PM_INDICATOR_INVERT = 5;
  localparam int PM_INDICATOR_PASS = 6;
  localparam int PM_PROTECT_DISABLE = 7;
  localparam logic [7:0] PM_RESET = 8'h00;

  // vbus_and_line_control fields
  localparam int VL_CABLE_ID_SENSE_ON = 0;
  localparam int VL_PLUS_LINE_PULL_LOW = 1;
  localparam int VL_MINUS_LINE_PULL_LOW = 2;
  localparam int VL_VBUS_DISCHARGE = 3;
  localparam int VL_VBUS_CHARGE = 4;
  localparam int VL_POWER_SWITCH_DRIVE = 6;
  localparam int VL_EXTERNAL_VBUS_VALID_SEL = 7;
  localparam logic [7:0] VL_RESET = 8'h06;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_SET,
    OP_CLEAR
  } reg_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WR_DATA,
    ST_WR_STOP,
    ST_RD_TURN,
    ST_RD_DATA,
    ST_RD_BACK
  } access_state_t;

endpackage : ulpi_regs_pkg

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic stp_i, data_oe_o, dir_o, nxt_o, indicator_o, vbus_valid_o;
  logic [7:0] data_i, data_o, line_vec, mode_vec;
  logic fault_i = 1'b0;
  logic vbus_cmp_i = 1'b0;
  logic global_low_power_n_i = 1'b1;
  logic power_switch_out_n_o, minus_line_pull_low_o, plus_line_pull_low_o;
  logic vbus_charge_o, vbus_discharge_o, cable_id_sense_on_o, carkit_uart_o;
  logic three_wire_serial_o, six_wire_serial_o, clk_power_on_o;
  int errors = 0;
  int n_compared = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  ulpi_phy_interface_otg_ctrl_regs uut (.sys_clk_i, .rst_n_i, .stp_i, .data_i, .data_o,
    .data_oe_o, .dir_o, .nxt_o, .fault_i, .vbus_cmp_i, .global_low_power_n_i,
    .indicator_o, .vbus_valid_o, .power_switch_out_n_o, .minus_line_pull_low_o,
    .plus_line_pull_low_o, .vbus_charge_o, .vbus_discharge_o, .cable_id_sense_on_o,
    .carkit_uart_o, .three_wire_serial_o, .six_wire_serial_o, .clk_power_on_o);
  ulpi_link_model link (.sys_clk_i, .dir_i(dir_o), .data_oe_i(data_oe_o),
    .phy_data_i(data_o), .stp_o(stp_i), .data_o(data_i));
  // Register layout view; bits 7 and 5 have no pin
  assign line_vec = {1'b0, ~power_switch_out_n_o, 1'b0, vbus_charge_o, vbus_discharge_o,
    minus_line_pull_low_o, plus_line_pull_low_o, cable_id_sense_on_o};
  assign mode_vec = {5'h00, carkit_uart_o, three_wire_serial_o, six_wire_serial_o};
  task automatic complete_run();
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [5:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    link.rd(addr, v, ok);
    chk({7'h00, ok}, 8'h01);
    chk(v, exp);
    if (ok !== 1'b1)
      complete_run();
  endtask : rdchk
  task automatic t_reset();
    @(negedge sys_clk_i);
    chk(line_vec, 8'h06);
    chk(mode_vec, 8'h00);
    rdchk(ulpi_regs_pkg::ADDR_PORT_MODE_WR, 8'h00);
    rdchk(ulpi_regs_pkg::ADDR_VBUS_LINE_CLR, 8'h06);
  endtask : t_reset
  task automatic t_access();
    logic [7:0] vals [2][3] = '{'{8'ha0, 8'h58, 8'h88}, '{8'hc1, 8'h1c, 8'h45}};
    logic [5:0] base;
    logic [7:0] exp;
    exp = 8'h00;
    for (int r = 0; r < 2; r++)
    begin
      base = r ? ulpi_regs_pkg::ADDR_VBUS_LINE_WR : ulpi_regs_pkg::ADDR_PORT_MODE_WR;
      for (int k = 0; k < 3; k++)
      begin
        link.wr(base + 6'(k), vals[r][k]);
        exp = k == 0 ? vals[r][k] : k == 1 ? exp | vals[r][k] : exp & ~vals[r][k];
        for (int a = 0; a < 3; a++)
          rdchk(base + 6'(a), exp);
        if (r == 1)
          chk(line_vec, exp & 8'h5f);
      end
    end
    link.wr(6'h15, 8'hff);
    rdchk(6'h15, 8'h00);
    link.wr_abort(ulpi_regs_pkg::ADDR_VBUS_LINE_WR, 8'h00);
    rdchk(ulpi_regs_pkg::ADDR_VBUS_LINE_WR, exp);
  endtask : t_access
  task automatic t_indicator();
    logic [2:0] c;
    logic [1:0] exp;
    for (int n = 0; n < 8; n++)
    begin
      c = 3'(n);
      link.wr(ulpi_regs_pkg::ADDR_PORT_MODE_WR, {2'h0, c[1], 5'h00});
      link.wr(ulpi_regs_pkg::ADDR_VBUS_LINE_WR, {c[2], 7'h06});
      @(posedge sys_clk_i);
      fault_i <= c[0];
      vbus_cmp_i <= ~c[0];
      exp[1] = c[0] ^ c[1];
      exp[0] = c[2] ? exp[1] : ~c[0];
      // Two sync stages plus the output register
      repeat (4) @(negedge sys_clk_i);
      chk({6'h00, indicator_o, vbus_valid_o}, {6'h00, exp});
    end
  endtask : t_indicator
  task automatic t_modes();
    logic [7:0] pm;
    for (int n = 0; n < 6; n++)
    begin
      pm = {4'h0, n[0], 3'h0} | (8'h01 << (n >> 1));
      link.wr(ulpi_regs_pkg::ADDR_PORT_MODE_WR, pm);
      @(negedge sys_clk_i);
      chk(mode_vec, pm & 8'h07);
      chk({7'h00, carkit_uart_o}, {7'h00, link.uart_en});
      chk({7'h00, clk_power_on_o}, {7'h00, pm[2] | pm[3]});
      @(posedge sys_clk_i);
      global_low_power_n_i <= 1'b0;
      @(negedge sys_clk_i);
      chk({7'h00, clk_power_on_o}, 8'h00);
      @(posedge sys_clk_i);
      global_low_power_n_i <= 1'b1;
      link.stop_pulse();
      @(negedge sys_clk_i);
      chk(mode_vec, 8'h00);
      chk({7'h00, carkit_uart_o}, {7'h00, link.uart_en});
      rdchk(ulpi_regs_pkg::ADDR_PORT_MODE_SET, pm & 8'hf8);
    end
  endtask : t_modes
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_access();
    t_indicator();
    t_modes();
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    complete_run();
  end
endmodule : tb_top

// *** tb/ulpi_link_model.sv ***
`timescale 1ns/100ps
module ulpi_link_model (
  input wire logic sys_clk_i, // ULPI clock
  input wire logic dir_i, // PHY direction
  input wire logic data_oe_i, // PHY drives data
  input wire logic [7:0] phy_data_i, // PHY data
  output logic stp_o, // Stop to PHY
  output logic [7:0] data_o // Data to PHY
);
  // Link's copy of the carkit UART enables, kept in step with the mode
  logic uart_en = 1'b0;
  initial
  begin
    stp_o = 1'b0;
    data_o = 8'h00;
  end
  // Caller sets at most one mode bit per write
  task automatic wr(input logic [5:0] addr, input logic [7:0] val);
    if (addr == ulpi_regs_pkg::ADDR_PORT_MODE_WR)
      uart_en = val[ulpi_regs_pkg::PM_CARKIT_UART_SEL];
    @(posedge sys_clk_i);
    data_o <= {ulpi_regs_pkg::CMD_TYPE_REG_WR, addr};
    @(posedge sys_clk_i);
    data_o <= val;
    @(posedge sys_clk_i);
    stp_o <= 1'b1;
    @(posedge sys_clk_i);
    stp_o <= 1'b0;
    data_o <= 8'h00;
  endtask : wr
  task automatic rd(input logic [5:0] addr, output logic [7:0] val, output logic ok);
    ok = 1'b0;
    val = 8'h00;
    @(posedge sys_clk_i);
    data_o <= {ulpi_regs_pkg::CMD_TYPE_REG_RD, addr};
    @(posedge sys_clk_i);
    // Released bus shows inverse, never a stale command
    data_o <= ~{ulpi_regs_pkg::CMD_TYPE_REG_RD, addr};
    for (int i = 0; i < 8 && !ok; i++)
    begin
      @(posedge sys_clk_i);
      if (data_oe_i === 1'b1)
      begin
        val = phy_data_i;
        ok = 1'b1;
      end
    end
    for (int i = 0; i < 4 && dir_i !== 1'b0; i++)
      @(posedge sys_clk_i);
    if (dir_i !== 1'b0)
      ok = 1'b0;
    data_o <= 8'h00;
  endtask : rd
  // Stop arrives with the data byte, so the write must be dropped
  task automatic wr_abort(input logic [5:0] addr, input logic [7:0] val);
    @(posedge sys_clk_i);
    data_o <= {ulpi_regs_pkg::CMD_TYPE_REG_WR, addr};
    @(posedge sys_clk_i);
    data_o <= val;
    stp_o <= 1'b1;
    @(posedge sys_clk_i);
    stp_o <= 1'b0;
    data_o <= 8'h00;
  endtask : wr_abort
  task automatic stop_pulse();
    @(posedge sys_clk_i);
    stp_o <= 1'b1;
    uart_en = 1'b0;
    @(posedge sys_clk_i);
    stp_o <= 1'b0;
  endtask : stop_pulse
endmodule : ulpi_link_model

// *** tb/ulpi_regs_props.sv ***
`timescale 1ns/100ps
module ulpi_regs_props (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic stp_i, // Stop
  input wire logic dir_o, // Direction
  input wire logic nxt_o, // Next
  input wire logic data_oe_o, // Data enable
  input wire logic global_low_power_n_i, // Global run
  input wire logic power_switch_out_n_o, // Switch pin
  input wire logic minus_line_pull_low_o, // Minus pull
  input wire logic plus_line_pull_low_o, // Plus pull
  input wire logic vbus_charge_o, // Charge
  input wire logic vbus_discharge_o, // Discharge
  input wire logic cable_id_sense_on_o, // Id sense
  input wire logic carkit_uart_o, // Uart mode
  input wire logic three_wire_serial_o, // 3-pin mode
  input wire logic six_wire_serial_o, // 6-pin mode
  input wire logic clk_power_on_o // Clock power
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic alt;
  logic ser;
  assign alt = carkit_uart_o | three_wire_serial_o | six_wire_serial_o;
  assign ser = three_wire_serial_o | six_wire_serial_o;
  sequence read_tail;
    dir_o && !data_oe_o ##1 !dir_o;
  endsequence
  sequence data_then_turn;
    data_oe_o ##1 !data_oe_o;
  endsequence
  a_read_data_tail: assert property (data_oe_o |-> dir_o && !nxt_o ##1 read_tail)
    else $error("read data phase out of shape");
  a_read_turn_data: assert property ($rose(dir_o) |-> $past(nxt_o) ##0 data_then_turn)
    else $error("read turnaround out of shape");
  a_write_stop_end: assert property (nxt_o && $past(nxt_o) && stp_i && !dir_o |=> !nxt_o)
    else $error("write not closed by stop");
  a_mode_exit_clear: assert property (alt && stp_i && !nxt_o && !dir_o |=> !alt)
    else $error("mode bits not cleared on exit");
  a_regs_hold_quiet: assert property (!stp_i |=> $stable({power_switch_out_n_o,
    minus_line_pull_low_o, plus_line_pull_low_o, vbus_charge_o, vbus_discharge_o,
    cable_id_sense_on_o, alt, ser}))
    else $error("register output moved without stop");
  a_clk_keep_ignored: assert property (!ser || !global_low_power_n_i
    |-> clk_power_on_o == global_low_power_n_i)
    else $error("clock power not following global control");
  a_reset_line_ctrl: assert property ($rose(rst_n_i) |-> minus_line_pull_low_o
    && plus_line_pull_low_o && !vbus_charge_o && !vbus_discharge_o
    && !cable_id_sense_on_o && power_switch_out_n_o)
    else $error("line control reset value wrong");
  a_dir_no_nxt: assert property (dir_o |-> !nxt_o)
    else $error("next raised while phy owns bus");
endmodule : ulpi_regs_props

bind ulpi_phy_interface_otg_ctrl_regs ulpi_regs_props u_props (.sys_clk_i, .rst_n_i,
  .stp_i, .dir_o, .nxt_o, .data_oe_o, .global_low_power_n_i, .power_switch_out_n_o,
  .minus_line_pull_low_o, .plus_line_pull_low_o, .vbus_charge_o, .vbus_discharge_o,
  .cable_id_sense_on_o, .carkit_uart_o, .three_wire_serial_o, .six_wire_serial_o,
  .clk_power_on_o);
